/* mtp_output_port.sv */
/*
 * transport stream output port: parallel byte bus with start, valid and
 * block error strobes, byte clock and apb register file.
 * assumes packet bytes arrive from the decoder with a first-byte mark and
 * an uncorrectable flag, and a symbol tick pulse from the symbol clock.
 */
module mtp_output_port (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic symbol_lock_in,
    input wire logic symbol_tick_in,
    input wire logic pkt_valid_in,
    input wire logic pkt_first_in,
    input wire logic [7:0] pkt_data_in,
    input wire logic pkt_uncorrectable_in,
    output logic pkt_ready_out,
    output logic ts_byte_clock_out,
    output logic [7:0] ts_data_bus_out,
    output logic ts_packet_start_out,
    output logic ts_valid_out,
    output logic ts_block_error_n_out,
    output logic irq_out
);
    typedef struct packed {
        mtp_pkg::mtp_state_e state;
        logic [7:0] cnt;
        logic [7:0] data;
        logic start;
        logic valid;
        logic err_n;
        logic [7:0] clk_cfg;
        logic [7:0] ctrl0;
        logic [7:0] config_reg;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic lock_q;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mtp_port_s;

    mtp_port_s r;
    mtp_port_s next_r;

    logic launch;
    logic byte_clk;
    logic [7:0] rd_index;
    logic [7:0] rd_data;
    logic buf_full;
    logic buf_unc;
    logic buf_release;
    logic [2:0] events;
    logic [2:0] irq_clear;
    logic wr_done;
    logic [31:0] rd_value;
    logic mapped;

    function automatic logic hit(input logic [11:0] addr,
                                 input logic [7:0] idx);
        return addr == mtp_pkg::mtp_reg_addr(idx);
    endfunction

    function automatic logic [7:0] out_byte(input logic [7:0] data,
                                            input logic [7:0] idx,
                                            input logic unc,
                                            input logic error_flag_insert_enable);
        logic [7:0] b;
        b = data;
        // only sets the bit; a bit already set passes through either way
        if (idx == mtp_pkg::TEI_BYTE_IDX && unc && error_flag_insert_enable) begin
            b[mtp_pkg::TEI_BIT] = 1'b1;
        end
        return b;
    endfunction

    mtp_clk_gen u_clk_gen (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .lock_in(symbol_lock_in),
        .symbol_tick_in(symbol_tick_in),
        .invert_in(r.clk_cfg[mtp_pkg::CLK_INV_BIT]),
        .byte_clk_out(byte_clk),
        .launch_out(launch)
    );

    mtp_pkt_store u_store (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .wr_valid_in(pkt_valid_in),
        .wr_first_in(pkt_first_in),
        .wr_data_in(pkt_data_in),
        .wr_unc_in(pkt_uncorrectable_in),
        .wr_ready_out(pkt_ready_out),
        .rd_index_in(rd_index),
        .rd_data_out(rd_data),
        .full_out(buf_full),
        .unc_out(buf_unc),
        .release_in(buf_release)
    );

    // byte to be launched next: the first byte when idle, else the following one
    assign rd_index = (r.state == mtp_pkg::MTP_SEND) ? (r.cnt + 8'h01)
                                                    : mtp_pkg::PKT_FIRST_IDX;

    always_comb begin
        mapped = 1'b1;
        rd_value = 32'h0000_0000;
        if (hit(paddr_in, mtp_pkg::IDX_CLK_CFG)) begin
            rd_value = {24'h00_0000, r.clk_cfg};
        end else if (hit(paddr_in, mtp_pkg::IDX_CTRL0)) begin
            rd_value = {24'h00_0000, r.ctrl0};
        end else if (hit(paddr_in, mtp_pkg::IDX_CONFIG)) begin
            rd_value = {24'h00_0000, r.config_reg};
        end else if (hit(paddr_in, mtp_pkg::IDX_IRQ_STAT)) begin
            rd_value = {29'h0000_0000, r.irq_stat};
        end else if (hit(paddr_in, mtp_pkg::IDX_IRQ_MASK)) begin
            rd_value = {29'h0000_0000, r.irq_mask};
        end else if (hit(paddr_in, mtp_pkg::IDX_STATUS)) begin
            rd_value[mtp_pkg::ST_LOCK_BIT] = r.lock_q;
            rd_value[mtp_pkg::ST_SEND_BIT] = (r.state == mtp_pkg::MTP_SEND);
            rd_value[mtp_pkg::ST_FULL_BIT] = buf_full;
        end else begin
            mapped = 1'b0;
        end
    end

    always_comb begin
        next_r = r;
        events = 3'h0;
        irq_clear = 3'h0;
        buf_release = 1'b0;
        next_r.lock_q = symbol_lock_in;

        // apb: one wait state, write lands on the edge that sees pready
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        if (psel_in && penable_in && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.pslverr = ~mapped;
            next_r.prdata = (pwrite_in || !mapped) ? 32'h0000_0000 : rd_value;
        end
        wr_done = psel_in && penable_in && pwrite_in && r.pready &&
                  !r.pslverr && pstrb_in[0];
        if (wr_done) begin
            if (hit(paddr_in, mtp_pkg::IDX_CLK_CFG)) begin
                next_r.clk_cfg = pwdata_in[7:0];
            end else if (hit(paddr_in, mtp_pkg::IDX_CTRL0)) begin
                next_r.ctrl0 = pwdata_in[7:0];
            end else if (hit(paddr_in, mtp_pkg::IDX_CONFIG)) begin
                next_r.config_reg = pwdata_in[7:0];
            end else if (hit(paddr_in, mtp_pkg::IDX_IRQ_STAT)) begin
                irq_clear = pwdata_in[2:0];
            end else if (hit(paddr_in, mtp_pkg::IDX_IRQ_MASK)) begin
                next_r.irq_mask = pwdata_in[2:0];
            end
        end

        if (r.lock_q && !symbol_lock_in) begin
            events[mtp_pkg::IRQ_LOCK_LOST] = 1'b1;
        end

        case (r.state)
            mtp_pkg::MTP_IDLE: begin
                // start only on a launch edge, so every sync byte is edge aligned
                if (launch && buf_full &&
                    !r.config_reg[mtp_pkg::OUT_EN_N_BIT]) begin
                    next_r.state = mtp_pkg::MTP_SEND;
                    next_r.cnt = mtp_pkg::PKT_FIRST_IDX;
                    next_r.data = rd_data;
                    next_r.start = 1'b1;
                    next_r.valid = 1'b1;
                    next_r.err_n = ~buf_unc;
                end
            end
            mtp_pkg::MTP_SEND: begin
                if (!symbol_lock_in) begin
                    // a packet cut by lock loss is dropped, not resumed
                    next_r.state = mtp_pkg::MTP_IDLE;
                    next_r.data = 8'h00;
                    next_r.start = 1'b0;
                    next_r.valid = 1'b0;
                    next_r.err_n = 1'b1;
                    buf_release = 1'b1;
                end else if (launch) begin
                    next_r.start = 1'b0;
                    if (r.cnt == mtp_pkg::PKT_LAST_IDX) begin
                        next_r.state = mtp_pkg::MTP_IDLE;
                        next_r.data = 8'h00;
                        next_r.valid = 1'b0;
                        next_r.err_n = 1'b1;
                        buf_release = 1'b1;
                        events[mtp_pkg::IRQ_PKT_DONE] = 1'b1;
                        events[mtp_pkg::IRQ_PKT_ERR] = buf_unc;
                    end else begin
                        // every launch edge carries a byte: no holes
                        next_r.cnt = rd_index;
                        next_r.data = out_byte(rd_data, rd_index, buf_unc,
                            r.ctrl0[mtp_pkg::ERROR_FLAG_INSERT_ENABLE_BIT]);
                    end
                end
            end
            default: begin
                next_r.state = mtp_pkg::MTP_IDLE;
            end
        endcase

        // a new event beats a clear written in the same cycle
        next_r.irq_stat = (r.irq_stat & ~irq_clear) | events;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            r <= '{state: mtp_pkg::MTP_IDLE,
                   cnt: 8'h00,
                   data: 8'h00,
                   start: 1'b0,
                   valid: 1'b0,
                   err_n: 1'b1,
                   clk_cfg: mtp_pkg::CLK_CFG_RST,
                   ctrl0: mtp_pkg::CTRL0_RST,
                   config_reg: mtp_pkg::CONFIG_RST,
                   irq_stat: 3'h0,
                   irq_mask: mtp_pkg::IRQ_MASK_RST,
                   irq: 1'b0,
                   lock_q: 1'b0,
                   pready: 1'b0,
                   pslverr: 1'b0,
                   prdata: 32'h0000_0000};
        end else begin
            r <= next_r;
        end
    end

    assign prdata_out = r.prdata;
    assign pready_out = r.pready;
    assign pslverr_out = r.pslverr;
    assign ts_byte_clock_out = byte_clk;
    assign ts_data_bus_out = r.data;
    assign ts_packet_start_out = r.start;
    assign ts_valid_out = r.valid;
    assign ts_block_error_n_out = r.err_n;
    assign irq_out = r.irq;
endmodule

/* mtp_pkg.sv */
/*
 * constants and types shared by the transport stream output port.
 * assumes a 32-bit apb with 12-bit byte addresses; indices are word indices.
 */
package mtp_pkg;
    localparam logic [7:0] PKT_FIRST_IDX = 8'h00;
    localparam logic [7:0] PKT_LAST_IDX = 8'hbb;
    localparam logic [7:0] TEI_BYTE_IDX = 8'h01;
    localparam int TEI_BIT = 7;

    localparam logic [7:0] IDX_CLK_CFG = 8'h50;
    localparam logic [7:0] IDX_CTRL0 = 8'h5a;
    localparam logic [7:0] IDX_CONFIG = 8'h60;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h61;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h62;
    localparam logic [7:0] IDX_STATUS = 8'h63;

    localparam int CLK_INV_BIT = 0;
    localparam int ERROR_FLAG_INSERT_ENABLE_BIT = 0;
    localparam int OUT_EN_N_BIT = 0;
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_SEND_BIT = 1;
    localparam int ST_FULL_BIT = 2;

    localparam logic [7:0] CLK_CFG_RST = 8'h01;
    localparam logic [7:0] CTRL0_RST = 8'h01;
    localparam logic [7:0] CONFIG_RST = 8'h01;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    localparam int IRQ_PKT_DONE = 0;
    localparam int IRQ_PKT_ERR = 1;
    localparam int IRQ_LOCK_LOST = 2;

    typedef enum logic [0:0] {
        MTP_IDLE = 1'b0,
        MTP_SEND = 1'b1
    } mtp_state_e;

    function automatic logic [11:0] mtp_reg_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
endpackage

/* mtp_clk_gen.sv */
/*
 * byte clock generator: toggles the output byte clock on symbol ticks.
 * assumes symbol_tick_in is a one-cycle pulse from the symbol clock logic.
 */
module mtp_clk_gen (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic lock_in,
    input wire logic symbol_tick_in,
    input wire logic invert_in,
    output logic byte_clk_out,
    output logic launch_out
);
    typedef struct packed {
        logic clk;
    } mtp_cg_s;

    mtp_cg_s r;
    mtp_cg_s next_r;

    always_comb begin
        next_r = r;
        // clock parked low without lock; runs freely once locked
        if (!lock_in) begin
            next_r.clk = 1'b0;
        end else if (symbol_tick_in) begin
            next_r.clk = ~r.clk;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign byte_clk_out = r.clk;
    // launch on the falling edge when inverted, else on the rising edge
    assign launch_out = lock_in && symbol_tick_in && (r.clk == invert_in);
endmodule

/* mtp_pkt_store.sv */
/*
 * one-packet store: collects 188 bytes, then holds them until released.
 * assumes the writer marks the first byte of each packet.
 */
module mtp_pkt_store (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic wr_valid_in,
    input wire logic wr_first_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_unc_in,
    output logic wr_ready_out,
    input wire logic [7:0] rd_index_in,
    output logic [7:0] rd_data_out,
    output logic full_out,
    output logic unc_out,
    input wire logic release_in
);
    typedef struct packed {
        logic [7:0] wcnt;
        logic full;
        logic unc;
        logic ready;
    } mtp_st_s;

    mtp_st_s r;
    mtp_st_s next_r;
    logic [7:0] mem [0:187];
    logic accept;
    logic [7:0] wr_idx;

    assign accept = wr_valid_in && r.ready;
    assign wr_idx = wr_first_in ? mtp_pkg::PKT_FIRST_IDX : r.wcnt;

    always_comb begin
        next_r = r;
        if (accept) begin
            next_r.unc = wr_first_in ? wr_unc_in : (r.unc | wr_unc_in);
            if (wr_idx == mtp_pkg::PKT_LAST_IDX) begin
                next_r.full = 1'b1;
                next_r.wcnt = mtp_pkg::PKT_FIRST_IDX;
            end else begin
                next_r.wcnt = wr_idx + 8'h01;
            end
        end
        if (release_in) begin
            next_r.full = 1'b0;
        end
        // writer stalls while a whole packet waits, so a packet goes out unbroken
        next_r.ready = ~next_r.full;
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            r <= '{wcnt: 8'h00, full: 1'b0, unc: 1'b0, ready: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (accept) begin
            mem[wr_idx] <= wr_data_in;
        end
    end

    assign rd_data_out = mem[rd_index_in];
    assign wr_ready_out = r.ready;
    assign full_out = r.full;
    assign unc_out = r.unc;
endmodule

/* mtp_output_port_checker.sv */
/* checker: strobe, data and byte clock relations of the stream port.
   assumes it is bound to the ports of mtp_output_port. */
module mtp_output_port_checker (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic symbol_lock_in,
    input wire logic symbol_tick_in,
    input wire logic ts_byte_clock_out,
    input wire logic [7:0] ts_data_bus_out,
    input wire logic ts_packet_start_out,
    input wire logic ts_valid_out,
    input wire logic ts_block_error_n_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // byte clock toggles inside a packet, two per byte slot
    logic [8:0] cnt;
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in)
            cnt <= '0;
        else if ($rose(ts_valid_out))
            cnt <= '0;
        else if (ts_valid_out && $changed(ts_byte_clock_out))
            cnt <= cnt + 9'h001;
    end
    sequence s_end;
        $fell(ts_valid_out) ##0 symbol_lock_in;
    endsequence
    sequence s_first;
        ts_packet_start_out ##0 !$rose(ts_valid_out);
    endsequence
    property p_len;
        s_end |-> cnt == 9'h177;
    endproperty
    a_len: assert property (p_len) else $error("packet length wrong");
    property p_start;
        s_first |-> cnt <= 9'h001 && ts_valid_out;
    endproperty
    a_start: assert property (p_start) else $error("start too long");
    property p_gap;
        !ts_valid_out |-> ts_data_bus_out == 8'h00;
    endproperty
    a_gap: assert property (p_gap) else $error("gap data not zero");
    property p_err;
        !ts_block_error_n_out |-> ts_valid_out;
    endproperty
    a_err: assert property (p_err) else $error("error outside packet");
    property p_err_hold;
        ts_valid_out && $past(ts_valid_out) |-> $stable(ts_block_error_n_out);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error moved");
    property p_edge;
        ($changed(ts_data_bus_out) || $changed(ts_valid_out)) && symbol_lock_in
            |-> $changed(ts_byte_clock_out);
    endproperty
    a_edge: assert property (p_edge) else $error("change off clock");
    property p_no_lock;
        !symbol_lock_in |=> !ts_byte_clock_out;
    endproperty
    a_no_lock: assert property (p_no_lock) else $error("clock without lock");
    property p_tick;
        symbol_tick_in && symbol_lock_in |=> $changed(ts_byte_clock_out);
    endproperty
    a_tick: assert property (p_tick) else $error("clock missed a tick");
    property p_idle;
        !symbol_tick_in && symbol_lock_in
            |=> !symbol_lock_in || $stable(ts_byte_clock_out);
    endproperty
    a_idle: assert property (p_idle) else $error("clock moved early");
endmodule

/* mtp_ts_sink.sv */
/* receiver model: samples the stream on the byte clock edge opposite
   to the launch edge. assumes the bench tells it the invert setting. */
module mtp_ts_sink (
    input wire logic inv_in,
    input wire logic bclk_in,
    input wire logic [7:0] data_in,
    input wire logic start_in,
    input wire logic valid_in,
    input wire logic err_n_in,
    output logic [15:0] pkts_out,
    output logic [8:0] len_out,
    output logic [7:0] b0_out,
    output logic [7:0] b1_out,
    output logic err_out
);
    logic [8:0] n = '0;
    logic was = 1'h0;
    initial pkts_out = '0;
    task grab();
        if (valid_in && start_in) begin
            n = 9'h001;
            b0_out = data_in;
            err_out = !err_n_in;
        end else if (valid_in) begin
            if (n == 9'h001)
                b1_out = data_in;
            n = n + 9'h001;
            err_out = err_out | !err_n_in;
        end else if (was) begin
            len_out = n;
            pkts_out = pkts_out + 16'h0001;
        end
        was = valid_in;
    endtask
    // rising edge is the better hold margin, used by default
    // rising edge with invert set, falling edge with it cleared
    always @(bclk_in) if (bclk_in == inv_in) grab();
endmodule

/* tb_mtp_output_port.sv */
/* testbench: registers over apb, packets in, stream checked by a sink.
   assumes the design, its package, the sink and the checker are compiled. */
module tb_mtp_output_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, symbol_lock_in = 0, symbol_tick_in = 0;
    logic pkt_valid_in = 0, pkt_first_in = 0, pkt_uncorrectable_in = 0;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0;
    logic [3:0] pstrb_in = '0;
    logic [7:0] pkt_data_in = '0;
    logic [31:0] prdata_out, rd;
    logic [7:0] ts_data_bus_out, b0, b1;
    logic pready_out, pslverr_out, pkt_ready_out, ts_byte_clock_out, er;
    logic ts_packet_start_out, ts_valid_out, ts_block_error_n_out, irq_out;
    logic inv = 1, err;
    logic [15:0] pkts;
    logic [8:0] len;
    int fail_count = 0, comparisons = 0, cyc = 0;
    // error_flag_insert_enable, unc, byte1 in, byte1 out, error strobe seen
    logic [18:0] rows [4] = '{{1'h1, 1'h1, 8'h01, 8'h81, 1'h1},
        {1'h0, 1'h1, 8'h01, 8'h01, 1'h1}, {1'h0, 1'h1, 8'h81, 8'h81, 1'h1},
        {1'h1, 1'h0, 8'h01, 8'h01, 1'h0}};
    mtp_output_port u_dut (.ref_clk_in, .reset_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
        .pready_out, .pslverr_out, .symbol_lock_in, .symbol_tick_in,
        .pkt_valid_in, .pkt_first_in, .pkt_data_in, .pkt_uncorrectable_in,
        .pkt_ready_out, .ts_byte_clock_out, .ts_data_bus_out,
        .ts_packet_start_out, .ts_valid_out, .ts_block_error_n_out, .irq_out);
    mtp_ts_sink u_sink (.inv_in(inv), .bclk_in(ts_byte_clock_out),
        .data_in(ts_data_bus_out), .start_in(ts_packet_start_out),
        .valid_in(ts_valid_out), .err_n_in(ts_block_error_n_out),
        .pkts_out(pkts), .len_out(len), .b0_out(b0), .b1_out(b1),
        .err_out(err));
    always #12.5 ref_clk_in = ~ref_clk_in;
    // symbol tick every other cycle gives a four-cycle byte slot
    always @(posedge ref_clk_in) symbol_tick_in <= ~symbol_tick_in;
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task stop_test();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= {2'h0, idx, 2'h0};
        pwdata_in <= d;
        pstrb_in <= 4'h1;
        @(posedge ref_clk_in);
        penable_in <= 1;
        do @(posedge ref_clk_in); while (pready_out !== 1'h1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
        @(posedge ref_clk_in);
    endtask
    task rchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(0, idx, 32'h0000_0000);
        chk("register", rd, exp);
    endtask
    task send(input logic u, input logic [7:0] b1v);
        for (int i = 0; i < 188; i++) begin
            pkt_valid_in <= 1;
            pkt_first_in <= (i == 0);
            pkt_uncorrectable_in <= u;
            pkt_data_in <= (i == 0) ? 8'h47 : (i == 1) ? b1v : 8'(i);
            do @(posedge ref_clk_in); while (pkt_ready_out !== 1'h1);
        end
        pkt_valid_in <= 0;
    endtask
    task expect_pkt(input logic [15:0] p0, input logic [7:0] eb1, input ee);
        repeat (3000) if (pkts == p0) @(posedge ref_clk_in);
        chk("packets", 32'(pkts), 32'(p0) + 1);
        chk("length", 32'(len), 32'd188);
        chk("byte0", 32'(b0), 32'h0000_0047);
        chk("byte1", 32'(b1), 32'(eb1));
        chk("error", 32'(err), 32'(ee));
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_in);
        reset_in <= 0;
        @(posedge ref_clk_in);
        rchk(mtp_pkg::IDX_CLK_CFG, 32'(mtp_pkg::CLK_CFG_RST));
        rchk(mtp_pkg::IDX_CTRL0, 32'(mtp_pkg::CTRL0_RST));
        rchk(mtp_pkg::IDX_CONFIG, 32'(mtp_pkg::CONFIG_RST));
        rchk(mtp_pkg::IDX_IRQ_MASK, 32'(mtp_pkg::IRQ_MASK_RST));
        rchk(8'h00, 32'h0000_0000);
        chk("slverr", 32'(er), 32'h0000_0001);
        symbol_lock_in <= 1;
        send(1'h0, 8'h01);
        repeat (1500) @(posedge ref_clk_in);
        chk("held", 32'(pkts), 32'h0000_0000);
        chk("ready", 32'(pkt_ready_out), 32'h0000_0000);
        rchk(mtp_pkg::IDX_STATUS, 32'h0000_0005);
        apb(1, mtp_pkg::IDX_CONFIG, 32'h0000_0000);
        expect_pkt(16'h0000, 8'h01, 1'h0);
        foreach (rows[r]) begin
            apb(1, mtp_pkg::IDX_CTRL0, 32'(rows[r][18]));
            send(rows[r][17], rows[r][16:9]);
            expect_pkt(pkts, rows[r][8:1], rows[r][0]);
        end
        chk("irq", 32'(irq_out), 32'h0000_0000);
        apb(1, mtp_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        chk("irq", 32'(irq_out), 32'h0000_0001);
        rchk(mtp_pkg::IDX_IRQ_STAT, 32'h0000_0003);
        apb(1, mtp_pkg::IDX_IRQ_STAT, 32'h0000_0001);
        chk("irq", 32'(irq_out), 32'h0000_0000);
        rchk(mtp_pkg::IDX_IRQ_STAT, 32'h0000_0002);
        apb(1, mtp_pkg::IDX_CLK_CFG, 32'h0000_0000);
        inv = 0;
        send(1'h1, 8'h01);
        expect_pkt(pkts, 8'h81, 1'h1);
        apb(1, mtp_pkg::IDX_CLK_CFG, 32'h0000_0001);
        inv = 1;
        symbol_lock_in <= 0;
        repeat (4) @(posedge ref_clk_in);
        chk("clock", 32'(ts_byte_clock_out), 32'h0000_0000);
        rchk(mtp_pkg::IDX_IRQ_STAT, 32'h0000_0007);
        chk("irq", 32'(irq_out), 32'h0000_0001);
        stop_test();
    end
endmodule
bind mtp_output_port mtp_output_port_checker u_chk (.ref_clk_in, .reset_in,
    .symbol_lock_in, .symbol_tick_in, .ts_byte_clock_out, .ts_data_bus_out,
    .ts_packet_start_out, .ts_valid_out, .ts_block_error_n_out);
